// ===== hdl/sat_lane.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Shared constants and operation codes
// ****************************************************************
package sat_alu_pkg;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int HALF_LANES = WORD_W / HALF_W;
    localparam int BYTE_LANES = WORD_W / BYTE_W;
    localparam logic [WORD_W-1:0] RESULT_RST = 32'h0000_0000;
    localparam logic SAT_FLAG_RST = 1'b0;

    typedef enum logic [2:0] {
        op_sat_double_add,
        op_sat_double_sub,
        op_sat_sub_word,
        op_sat_sub_add_exchange,
        op_sat_sub_halfwords,
        op_sat_sub_bytes
    } op_e;
endpackage

// ****************************************************************
// One signed lane: add or subtract, clamped to the lane width
// ****************************************************************
module sat_lane #(
    parameter int W = 32
) (
    input wire logic [W-1:0] lane_a,
    input wire logic [W-1:0] lane_b,
    input wire logic lane_sub,
    output logic [W-1:0] lane_res,
    output logic lane_sat
);
    logic [W:0] ax;
    logic [W:0] bx;
    logic [W:0] sum;

    // One guard bit is enough: a W-bit sum or difference fits in W+1 bits
    assign ax = {lane_a[W-1], lane_a};
    assign bx = {lane_b[W-1], lane_b};
    assign sum = lane_sub ? (ax - bx) : (ax + bx);
    assign lane_sat = sum[W] ^ sum[W-1];
    assign lane_res = lane_sat ? (sum[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}})
                               : sum[W-1:0];
endmodule

`default_nettype wire

// ===== hdl/saturating_subtract_double_alu.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - Double add: saturate 2*second, add first, saturate
// RULE2 - Double sub: saturate 2*second, subtract from first
// RULE3 - Doubling ops set flag on either saturation
// RULE4 - Word subtract first minus second, clamp, flag
// RULE5 - Exchange low: first low plus second high
// RULE6 - Exchange high: first high minus second low
// RULE7 - Halfword lanes subtract independently, clamp to 16
// RULE8 - Four byte lanes subtract independently, clamp to 8
// RULE9 - Caller avoids registers 13 and 15
// RULE10 - Result and flag only set when condition check passes; sat_clr clears flag regardless
// RULE11 - Saturation flag is sticky, set by ops, cleared only by sat_clr
// RULE12 - Packed and exchange ops never touch flag
module saturating_subtract_double_alu
    import sat_alu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic op_valid,
    input wire logic cond_pass,
    input wire op_e op_sel,
    input wire logic [WORD_W-1:0] op_first,
    input wire logic [WORD_W-1:0] op_second,
    input wire logic sat_clr,
    output logic [WORD_W-1:0] result,
    output logic result_valid,
    output logic sat_flag
);
    typedef struct packed {
        logic [WORD_W-1:0] result;
        logic res_valid;
        logic sat_flag;
    } alu_state_s;

    alu_state_s st_q;
    alu_state_s st_d;

    logic issue;
    logic is_double;
    logic is_xchg;
    logic [WORD_W-1:0] dbl_res;
    logic dbl_sat;
    logic [WORD_W-1:0] word_b;
    logic [WORD_W-1:0] word_res;
    logic word_sat;
    logic [WORD_W-1:0] half_res;
    logic [WORD_W-1:0] byte_res;

    // ************************************************************
    // Datapath
    // ************************************************************
    assign issue = op_valid & cond_pass;
    assign is_double = (op_sel == op_sat_double_add) || (op_sel == op_sat_double_sub);
    assign is_xchg = (op_sel == op_sat_sub_add_exchange);

    // Doubling is second + second through the same clamp as any add
    sat_lane #(.W(WORD_W)) u_double (
        .lane_a(op_second),
        .lane_b(op_second),
        .lane_sub(1'b0),
        .lane_res(dbl_res),
        .lane_sat(dbl_sat)
    );

    assign word_b = is_double ? dbl_res : op_second;

    sat_lane #(.W(WORD_W)) u_word (
        .lane_a(op_first),
        .lane_b(word_b),
        .lane_sub(op_sel != op_sat_double_add),
        .lane_res(word_res),
        .lane_sat(word_sat)
    );

    genvar gi;
    generate
        for (gi = 0; gi < HALF_LANES; gi++) begin : g_half
            logic [HALF_W-1:0] hb;
            // Exchange swaps the second operand's halves; its low lane adds
            assign hb = is_xchg ? op_second[HALF_W*(HALF_LANES-1-gi) +: HALF_W]
                                : op_second[HALF_W*gi +: HALF_W]; // RULE5 RULE6
            sat_lane #(.W(HALF_W)) u_h (
                .lane_a(op_first[HALF_W*gi +: HALF_W]),
                .lane_b(hb),
                .lane_sub(!(is_xchg && (gi == 0))), // RULE5 RULE6 RULE7
                .lane_res(half_res[HALF_W*gi +: HALF_W]),
                .lane_sat()
            );
        end
        for (gi = 0; gi < BYTE_LANES; gi++) begin : g_byte
            sat_lane #(.W(BYTE_W)) u_b (
                .lane_a(op_first[BYTE_W*gi +: BYTE_W]),
                .lane_b(op_second[BYTE_W*gi +: BYTE_W]),
                .lane_sub(1'b1), // RULE8
                .lane_res(byte_res[BYTE_W*gi +: BYTE_W]),
                .lane_sat()
            );
        end
    endgenerate

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.res_valid = 1'b0;
        // Clear goes first so a saturation in the same cycle still sets
        if (sat_clr) begin
            st_d.sat_flag = 1'b0;
        end
        if (issue) begin // RULE10
            st_d.res_valid = 1'b1;
            case (op_sel)
                op_sat_double_add, op_sat_double_sub: begin
                    st_d.result = word_res; // RULE1 RULE2
                    if (dbl_sat || word_sat) begin
                        st_d.sat_flag = 1'b1; // RULE3 RULE11
                    end
                end
                op_sat_sub_word: begin
                    st_d.result = word_res; // RULE4
                    if (word_sat) begin
                        st_d.sat_flag = 1'b1; // RULE4 RULE11
                    end
                end
                op_sat_sub_add_exchange, op_sat_sub_halfwords: begin
                    st_d.result = half_res; // RULE12
                end
                op_sat_sub_bytes: begin
                    st_d.result = byte_res; // RULE12
                end
                default: begin
                    st_d.res_valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{result: RESULT_RST, res_valid: 1'b0, sat_flag: SAT_FLAG_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign result = st_q.result;
    assign result_valid = st_q.res_valid;
    assign sat_flag = st_q.sat_flag;

    // ************************************************************
    // Checks
    // ************************************************************
    // Reference clamp of a wide signed value to n bits; bit 32 flags clamping
    function automatic logic [WORD_W:0] ref_sat(input logic signed [33:0] v, input int n);
        logic signed [33:0] lmax;
        logic signed [33:0] lmin;
        lmax = (34'sd1 <<< (n - 1)) - 34'sd1;
        lmin = -lmax - 34'sd1;
        if (v > lmax) begin
            return {1'b1, lmax[WORD_W-1:0]};
        end else if (v < lmin) begin
            return {1'b1, lmin[WORD_W-1:0]};
        end
        return {1'b0, v[WORD_W-1:0]};
    endfunction

    // Sign-extend the n bits of x starting at bit lo
    function automatic logic signed [33:0] sx(input logic [WORD_W-1:0] x, input int lo,
                                              input int n);
        logic signed [WORD_W-1:0] u;
        u = (x >> lo) << (WORD_W - n);
        u = u >>> (WORD_W - n);
        return {{2{u[WORD_W-1]}}, u};
    endfunction

    logic [WORD_W:0] ref_dbl;
    logic [WORD_W:0] ref_dadd;
    logic [WORD_W:0] ref_dsub;
    logic [WORD_W:0] ref_wsub;
    assign ref_dbl = ref_sat(sx(op_second, 0, WORD_W) + sx(op_second, 0, WORD_W), WORD_W);
    assign ref_dadd = ref_sat(sx(op_first, 0, WORD_W) + sx(ref_dbl[WORD_W-1:0], 0, WORD_W),
                              WORD_W);
    assign ref_dsub = ref_sat(sx(op_first, 0, WORD_W) - sx(ref_dbl[WORD_W-1:0], 0, WORD_W),
                              WORD_W);
    assign ref_wsub = ref_sat(sx(op_first, 0, WORD_W) - sx(op_second, 0, WORD_W), WORD_W);

    // Lane references live in signals: a call result cannot be part-selected
    logic [WORD_W:0] ref_xlo;
    logic [WORD_W:0] ref_xhi;
    logic [WORD_W:0] ref_hlo;
    logic [WORD_W:0] ref_hhi;
    logic [WORD_W:0] ref_blo;
    assign ref_xlo = ref_sat(sx(op_first, 0, HALF_W) + sx(op_second, HALF_W, HALF_W),
                             HALF_W);
    assign ref_xhi = ref_sat(sx(op_first, HALF_W, HALF_W) - sx(op_second, 0, HALF_W),
                             HALF_W);
    assign ref_hlo = ref_sat(sx(op_first, 0, HALF_W) - sx(op_second, 0, HALF_W), HALF_W);
    assign ref_hhi = ref_sat(sx(op_first, HALF_W, HALF_W) - sx(op_second, HALF_W, HALF_W),
                             HALF_W);
    assign ref_blo = ref_sat(sx(op_first, 0, BYTE_W) - sx(op_second, 0, BYTE_W), BYTE_W);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_DBL_ADD: assert property (issue && op_sel == op_sat_double_add |=> // RULE1
        result == $past(ref_dadd[WORD_W-1:0])) else $error("double add result wrong");
    AST_DBL_SUB: assert property (issue && op_sel == op_sat_double_sub |=> // RULE2
        result == $past(ref_dsub[WORD_W-1:0])) else $error("double sub result wrong");
    AST_DBL_FLAG: assert property (issue && is_double && // RULE3
        (ref_dbl[WORD_W] || (op_sel == op_sat_double_add ? ref_dadd[WORD_W] : ref_dsub[WORD_W]))
        |=> sat_flag) else $error("doubling saturation did not set flag");
    AST_WORD_SUB: assert property (issue && op_sel == op_sat_sub_word |=> // RULE4
        result == $past(ref_wsub[WORD_W-1:0]) && (sat_flag || !$past(ref_wsub[WORD_W])))
        else $error("word subtract wrong");
    AST_XCHG_LO: assert property (issue && is_xchg |=> // RULE5
        result[HALF_W-1:0] == $past(ref_xlo[HALF_W-1:0])) else $error("exchange low half wrong");
    AST_XCHG_HI: assert property (issue && is_xchg |=> // RULE6
        result[WORD_W-1:HALF_W] == $past(ref_xhi[HALF_W-1:0]))
        else $error("exchange high half wrong");
    AST_HALF_SUB: assert property (issue && op_sel == op_sat_sub_halfwords |=> // RULE7
        result == $past({ref_hhi[HALF_W-1:0], ref_hlo[HALF_W-1:0]}))
        else $error("halfword subtract wrong");
    AST_BYTE_SUB: assert property (issue && op_sel == op_sat_sub_bytes |=> // RULE8
        result[BYTE_W-1:0] == $past(ref_blo[BYTE_W-1:0])) else $error("byte subtract wrong");
    AST_NO_ISSUE: assert property (!issue |=> !result_valid && $stable(result)) // RULE10
        else $error("state changed without condition pass");
    AST_STICKY: assert property (sat_flag && !sat_clr |=> sat_flag [*1]) // RULE11
        else $error("saturation flag cleared by hardware");
    AST_LANE_NOFLAG: assert property (issue && !is_double && op_sel != op_sat_sub_word // RULE12
        && !sat_clr |=> $stable(sat_flag)) else $error("lane op changed flag");

    COV_DBL_SAT: cover property (issue && is_double && ref_dbl[WORD_W] ##1 sat_flag);
    COV_BYTE: cover property (issue && op_sel == op_sat_sub_bytes ##1 result_valid);
    COV_CLR_SET: cover property (issue && op_sel == op_sat_sub_word && ref_wsub[WORD_W]
        && sat_clr ##1 sat_flag);
endmodule

`default_nettype wire

// ===== tb/reg_file_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Destination register file
// ****************************************
module reg_file_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_idx,
    input wire logic [3:0] rd_idx,
    output logic [31:0] rd_data,
    output logic [15:0] wr_cnt
);
    logic [31:0] regs_q [16];
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_cnt <= 16'h0000;
        end else if (wr_en) begin
            regs_q[wr_idx] <= wr_data;
            wr_cnt <= wr_cnt + 16'h0001;
        end
    end
    assign rd_data = regs_q[rd_idx];
endmodule
`default_nettype wire

// ===== tb/saturating_subtract_double_alu_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Self-checking bench
// ****************************************
module saturating_subtract_double_alu_tb_top;
    import sat_alu_pkg::*;
    logic clk_sys, nrst, op_valid, cond_pass, sat_clr, result_valid, sat_flag, exp_flag;
    op_e op_sel;
    logic [31:0] op_first, op_second, result, rd_data, exp_res, dest_exp;
    logic [3:0] wr_idx, rd_idx;
    logic dest_pend;
    logic [15:0] wr_cnt, taken_cnt;
    int error_cnt, comparisons;

    saturating_subtract_double_alu uut (.clk_sys(clk_sys), .nrst(nrst), .op_valid(op_valid),
        .cond_pass(cond_pass), .op_sel(op_sel), .op_first(op_first), .op_second(op_second),
        .sat_clr(sat_clr), .result(result), .result_valid(result_valid), .sat_flag(sat_flag));
    reg_file_model far_end (.clk_sys(clk_sys), .nrst(nrst), .wr_en(result_valid),
        .wr_data(result), .wr_idx(wr_idx), .rd_idx(rd_idx), .rd_data(rd_data),
        .wr_cnt(wr_cnt));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic longint sx(logic [31:0] v, int w);
        longint u = longint'(v) & ((longint'(1) <<< w) - 1);
        return u[w-1] ? u - (longint'(1) <<< w) : u;
    endfunction

    function automatic longint clampw(longint v, int w, output bit s);
        longint hi = (longint'(1) <<< (w - 1)) - 1;
        s = (v > hi) || (v < -hi - 1);
        return (v > hi) ? hi : ((v < -hi - 1) ? -hi - 1 : v);
    endfunction

    // Gives {flag set, result}; lane ops never report a flag
    function automatic logic [32:0] model(op_e op, logic [31:0] a, logic [31:0] b);
        longint d;
        longint acc = 0;
        bit s1, s2;
        int w = (op == op_sat_sub_bytes) ? 8 : 16;
        case (op)
            op_sat_double_add, op_sat_double_sub: begin
                d = clampw(2 * sx(b, 32), 32, s1);
                d = clampw(sx(a, 32) + ((op == op_sat_double_add) ? d : -d), 32, s2);
                return {s1 | s2, d[31:0]};
            end
            op_sat_sub_word: begin
                d = clampw(sx(a, 32) - sx(b, 32), 32, s1);
                return {s1, d[31:0]};
            end
            op_sat_sub_add_exchange: begin
                acc = clampw(sx(a, 16) + sx(b >> 16, 16), 16, s1) & 64'hffff;
                acc |= (clampw(sx(a >> 16, 16) - sx(b, 16), 16, s2) & 64'hffff) << 16;
                return {1'b0, acc[31:0]};
            end
            default: begin
                for (int i = 0; i < 32 / w; i++) begin
                    d = clampw(sx(a >> (w * i), w) - sx(b >> (w * i), w), w, s1);
                    acc |= (d & ((longint'(1) <<< w) - 1)) << (w * i);
                end
                return {1'b0, acc[31:0]};
            end
        endcase
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Entered at a falling edge; checks at the next one
    task automatic run(op_e op, logic [31:0] a, logic [31:0] b, logic v, logic cp, logic clr);
        logic [32:0] m;
        logic taken;
        op_valid = v;
        cond_pass = cp;
        op_sel = op;
        op_first = a;
        op_second = b;
        sat_clr = clr;
        m = model(op, a, b);
        taken = v && cp && (op <= op_sat_sub_bytes);
        @(negedge clk_sys);
        if (taken) exp_res = m[31:0];
        exp_flag = (exp_flag && !clr) || (taken && m[32]);
        taken_cnt += 16'(taken);
        check("result_valid", 32'(result_valid), 32'(taken));
        check("result", result, exp_res);
        check("sat_flag", 32'(sat_flag), 32'(exp_flag));
        // The write enable stands now, so the destination lands at the next edge
        if (dest_pend) check("dest", rd_data, dest_exp);
        wr_idx = 4'($urandom_range(12));
        rd_idx = wr_idx;
        dest_pend = taken;
        dest_exp = exp_res;
    endtask

    initial begin
        error_cnt = 0;
        comparisons = 0;
        taken_cnt = 16'h0000;
        exp_flag = SAT_FLAG_RST;
        exp_res = RESULT_RST;
        nrst = 1'b0;
        op_valid = 1'b0;
        cond_pass = 1'b0;
        sat_clr = 1'b0;
        op_sel = op_sat_double_add;
        op_first = 32'h0000_0000;
        op_second = 32'h0000_0000;
        wr_idx = 4'h0;
        rd_idx = 4'h0;
        dest_pend = 1'b0;
        dest_exp = 32'h0000_0000;
        void'($urandom(32'hdfa9));
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        check("rst_flag", 32'(sat_flag), 32'(SAT_FLAG_RST));
        run(op_sat_sub_add_exchange, 32'h8000_7fff, 32'h0001_0001, 1, 1, 0);
        run(op_sat_sub_halfwords, 32'h8000_7fff, 32'h0001_ffff, 1, 1, 0);
        run(op_sat_sub_bytes, 32'h807f_0080, 32'h01ff_ff01, 1, 1, 0);
        run(op_sat_double_add, 32'h0000_0005, 32'h0000_0003, 1, 1, 0);
        run(op_sat_double_add, 32'h0000_0000, 32'h4000_0000, 1, 1, 0);
        run(op_sat_sub_word, 32'h8000_0000, 32'h0000_0001, 1, 0, 1);
        run(op_e'(3'h6), 32'h1234_5678, 32'h0000_0001, 1, 1, 0);
        run(op_sat_sub_bytes, 32'h8000_0000, 32'h0100_0000, 0, 1, 1);
        run(op_sat_double_sub, 32'h8000_0000, 32'h0000_0001, 1, 1, 1);
        run(op_sat_sub_halfwords, 32'h0000_0000, 32'h0000_0000, 1, 1, 1);
        run(op_sat_sub_word, 32'h8000_0000, 32'h0000_0001, 1, 1, 0);
        for (int i = 0; i < 300; i++) begin
            run(op_e'($urandom_range(7)), $urandom, $urandom, 1'($urandom_range(9) > 0),
                1'($urandom_range(9) > 0), 1'($urandom_range(15) == 0));
        end
        run(op_sat_sub_word, 32'h0000_0000, 32'h0000_0000, 0, 0, 0);
        check("writes", 32'(wr_cnt), 32'(taken_cnt));
        give_verdict();
    end

    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
